// file: acm_mode_cal.sv
// Mode sequencing, calibration and correction control for a two-converter front end
`timescale 1ns/1ps
// Overview of operation
// R01: Mode field 000 puts the whole device into power-down.
// R02: After reset the mode field reads power-down until software changes it.
// R03: Clearing a converter's enable bit powers that converter off alone.
// R04: Power-down and converter-disable keep every register, data included, unchanged, apart from the ready flags that a power-down mode write clears.
// R05: The register bus keeps working in whole-device power-down.
// R06: Entering power-down or idle drives the active-low ready output high; code does this only on a mode write, not on the R07/R08 return to idle.
// R07: Any finished calibration returns the mode field to idle.
// R08: A finished single conversion returns the mode field to idle.
// R09: Both enables low with non-zero mode: converters off, clock and switches on.
// R10: Four calibration modes exist, each chosen by a mode code.
// R11: Reset loads the factory gain coefficient into each gain register.
// R12: Each converter has its own offset and gain register.
// R13: A calibration overwrites the factory coefficient with the measured value.
// R14: Zero-scale results go to the calibrated converter's offset register.
// R15: Full-scale results go to the calibrated converter's gain register.
// R16: Internal calibrations route the internal zero or full input to the converter.
// R17: Host applies system zero or full voltage before starting system calibration.
// R18: Calibrations always run at the slowest update rate.
// R19: Correction subtracts the offset, then multiplies by the normalised gain.
// R20: Host should run zero-scale calibration before full-scale calibration.
// R21: Each converter's ready flag in status marks end of calibration.
// R22: Missing reference during calibration blocks the update and sets the error flag.
// R23: During reset the ready output is high and register accesses are ignored.
// R24: Writing a non-zero conversion or calibration code starts that operation.
module acm_mode_cal #(
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register bus
  input wire acm_pkg::acm_avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Filter words, main at index 0, auxiliary at index 1
  input wire acm_pkg::acm_sample_t [1:0] sample_i,
  // Reference detect pin, asynchronous
  input wire logic ref_missing_i,
  // Converter and device controls
  output acm_pkg::acm_conv_t [1:0] conv_o,
  output logic pll_en_o,
  output logic aux_func_en_o,
  output logic data_ready_n_o
);
  import acm_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (DW < 8 || DW > 31) begin : g_bad_dw
    $error("acm_mode_cal: DW must lie in 8..31");
  end

  localparam int PW = 2 * DW + 2;
  localparam logic [DW-1:0] ALL_ONES = {DW{1'b1}};

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Reference detect synchroniser
  logic refm_meta_r;
  logic refm_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      refm_meta_r <= 1'b0;
      refm_r <= 1'b0;
    end else begin
      refm_meta_r <= ref_missing_i;
      refm_r <= refm_meta_r;
    end
  end

  // ==========================================================
  // Bus slave: one wait cycle, then the answer
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic req;
  logic wr_acc;
  logic rd_acc;

  assign req = avs_req_i.read | avs_req_i.write;
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_acc = avs_req_i.write & ack_r;
  assign rd_acc = avs_req_i.read & ack_r;
  assign avs_readdata_o = rdata_r;

  // ==========================================================
  // Control registers
  acm_mode_t mode_r;
  acm_mode_t mode_nxt;
  logic [1:0] en_r;
  logic [1:0] en_nxt;
  logic [7:0] rate_r;
  logic [7:0] rate_nxt;
  logic [1:0] rdy_r;
  logic [1:0] rdy_nxt;
  logic [1:0] got_r;
  logic [1:0] got_nxt;
  logic err_r;
  logic err_nxt;
  logic [DW-1:0] data_r [2];
  logic [DW-1:0] data_nxt [2];
  logic [DW-1:0] ofs_r [2];
  logic [DW-1:0] ofs_nxt [2];
  logic [DW-1:0] gain_r [2];
  logic [DW-1:0] gain_nxt [2];
  logic [DW-1:0] corr [2];
  logic [1:0] take;

  logic running;
  logic is_cal;
  logic is_zero;
  logic one_shot;
  logic finish;
  logic mode_wr;
  logic cal_ok;

  assign running = (mode_r != MD_PD) && (mode_r != MD_IDLE);
  assign is_cal = mode_r[2]; // R10
  assign is_zero = (mode_r == MD_INT_ZERO) || (mode_r == MD_SYS_ZERO);
  assign one_shot = is_cal || (mode_r == MD_SINGLE);
  assign finish = one_shot && ((got_r | ~en_r) == 2'b11);
  assign mode_wr = wr_acc && (avs_req_i.address == REG_MODE) && avs_req_i.byteenable[0];
  // Calibration stays blocked from the first missing-reference cycle on
  assign cal_ok = is_cal && !err_r && !refm_r; // R22

  // ==========================================================
  // Per-converter sampling and correction
  genvar c;
  for (c = 0; c < 2; c++) begin : g_ch
    logic signed [DW:0] diff;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] scaled;

    // Only an enabled converter in an active mode consumes filter words
    assign take[c] = sample_i[c].valid && en_r[c] && running && !got_r[c]; // R04
    assign diff = $signed({1'b0, sample_i[c].word[DW-1:0]}) - $signed({1'b0, ofs_r[c]}); // R19
    assign prod = PW'(diff) * $signed({{(DW+1){1'b0}}, gain_r[c]}); // R19
    // Gain is normalised with unity at the top bit, bit DW-1, above DW-1 fraction bits
    assign scaled = prod >>> (DW - 1); // R19
    assign corr[c] = scaled < 0 ? '0 :
                     (scaled > $signed(PW'(ALL_ONES)) ? ALL_ONES : scaled[DW-1:0]);

    always_comb begin
      conv_o[c].pwr = en_r[c] && (mode_r != MD_PD); // R01 R03 R09
      conv_o[c].rate = is_cal ? RATE_SLOWEST : rate_r; // R18
      case (mode_r)
        MD_INT_ZERO: conv_o[c].in_sel = IN_ZERO; // R16
        MD_INT_FULL: conv_o[c].in_sel = IN_FULL; // R16
        default: conv_o[c].in_sel = IN_EXT;
      endcase
    end
  end

  // Clock multiplier and switches stay usable whenever the mode is non-zero
  assign pll_en_o = (mode_r != MD_PD); // R09
  assign aux_func_en_o = (mode_r != MD_PD); // R09
  assign data_ready_n_o = ~|rdy_r; // R06 R21

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [31:0] cur;
    cur = '0;
    ack_nxt = req & ~ack_r;
    mode_nxt = mode_r;
    en_nxt = en_r;
    rate_nxt = rate_r;
    rdy_nxt = rdy_r;
    got_nxt = got_r;
    err_nxt = err_r;
    data_nxt = data_r;
    ofs_nxt = ofs_r;
    gain_nxt = gain_r;
    rdata_nxt = '0;

    // Sequencer side
    if (finish) begin
      mode_nxt = MD_IDLE; // R07 R08
      got_nxt = '0;
    end
    if (is_cal && refm_r) begin
      err_nxt = 1'b1; // R22
    end
    for (int k = 0; k < 2; k++) begin
      if (take[k]) begin
        if (one_shot) begin
          got_nxt[k] = 1'b1;
        end
        if (!is_cal) begin
          // Absent reference clamps the result to all ones
          data_nxt[k] = refm_r ? ALL_ONES : corr[k];
          rdy_nxt[k] = 1'b1;
        end else begin
          if (cal_ok && is_zero) begin
            ofs_nxt[k] = sample_i[k].word[DW-1:0]; // R13 R14
          end
          if (cal_ok && !is_zero) begin
            gain_nxt[k] = sample_i[k].word[DW-1:0]; // R13 R15
          end
          rdy_nxt[k] = 1'b1; // R21
        end
      end
    end

    // Bus side; reading a data word clears its ready flag unless a new word lands
    if (rd_acc) begin
      for (int k = 0; k < 2; k++) begin
        if (avs_req_i.address == REG_DATA0 + REG_STRIDE * 8'(k) && !take[k]) begin
          rdy_nxt[k] = 1'b0;
        end
      end
    end
    if (mode_wr) begin
      mode_nxt = acm_mode_t'(avs_req_i.writedata[2:0]); // R24
      got_nxt = '0;
      if (avs_req_i.writedata[2:0] <= 3'(MD_IDLE)) begin
        rdy_nxt = '0; // R06
      end
      // A reference fault seen in the same cycle wins over the clear
      if (avs_req_i.writedata[2] && !(is_cal && refm_r)) begin
        err_nxt = 1'b0;
      end
    end
    if (wr_acc) begin
      if (avs_req_i.address == REG_MAIN_CTRL && avs_req_i.byteenable[0]) begin
        en_nxt[0] = avs_req_i.writedata[EN_BIT]; // R03
      end
      if (avs_req_i.address == REG_AUX_CTRL && avs_req_i.byteenable[0]) begin
        en_nxt[1] = avs_req_i.writedata[EN_BIT]; // R03
      end
      if (avs_req_i.address == REG_RATE && avs_req_i.byteenable[0]) begin
        rate_nxt = avs_req_i.writedata[7:0];
      end
      for (int k = 0; k < 2; k++) begin
        if (avs_req_i.address == REG_OFS0 + REG_STRIDE * 8'(k)) begin
          cur = be_merge(32'(ofs_r[k]), avs_req_i.writedata, avs_req_i.byteenable);
          ofs_nxt[k] = cur[DW-1:0];
        end
        if (avs_req_i.address == REG_GAIN0 + REG_STRIDE * 8'(k)) begin
          cur = be_merge(32'(gain_r[k]), avs_req_i.writedata, avs_req_i.byteenable);
          gain_nxt[k] = cur[DW-1:0];
        end
      end
    end

    // Read mux, unmapped offsets read zero
    case (avs_req_i.address)
      REG_MODE: rdata_nxt = 32'(mode_r);
      REG_MAIN_CTRL: rdata_nxt = 32'(en_r[0]);
      REG_AUX_CTRL: rdata_nxt = 32'(en_r[1]);
      REG_RATE: rdata_nxt = 32'(rate_r);
      REG_STATUS: begin
        rdata_nxt[ST_MAIN_RDY] = rdy_r[0]; // R21
        rdata_nxt[ST_AUX_RDY] = rdy_r[1]; // R21
        rdata_nxt[ST_MAIN_ERR] = err_r;
        rdata_nxt[ST_NOREF] = refm_r;
      end
      default: begin
        for (int k = 0; k < 2; k++) begin
          if (avs_req_i.address == REG_DATA0 + REG_STRIDE * 8'(k)) begin
            rdata_nxt = 32'(data_r[k]);
          end
          if (avs_req_i.address == REG_OFS0 + REG_STRIDE * 8'(k)) begin
            rdata_nxt = 32'(ofs_r[k]); // R12
          end
          if (avs_req_i.address == REG_GAIN0 + REG_STRIDE * 8'(k)) begin
            rdata_nxt = 32'(gain_r[k]); // R12
          end
        end
      end
    endcase
  end

  // ==========================================================
  // State registers; the bus answers in every mode, power-down included
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_r <= 1'b0; // R23
      rdata_r <= '0;
      mode_r <= MD_PD; // R02
      en_r <= '0;
      rate_r <= RATE_RESET;
      rdy_r <= '0; // R23
      got_r <= '0;
      err_r <= 1'b0;
      for (int k = 0; k < 2; k++) begin
        data_r[k] <= '0;
        ofs_r[k] <= OFS_RESET[DW-1:0];
        gain_r[k] <= FACTORY_GAIN[DW-1:0]; // R11
      end
    end else begin
      ack_r <= ack_nxt; // R05
      rdata_r <= rdata_nxt;
      mode_r <= mode_nxt;
      en_r <= en_nxt;
      rate_r <= rate_nxt;
      rdy_r <= rdy_nxt;
      got_r <= got_nxt;
      err_r <= err_nxt;
      data_r <= data_nxt;
      ofs_r <= ofs_nxt;
      gain_r <= gain_nxt;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_cal_run;
    is_cal && !mode_wr;
  endsequence

  sequence s_all_taken;
    finish && !mode_wr;
  endsequence

  a_reset_powerdown: assert property ( // R02
    $past(srst_i) |-> mode_r == MD_PD && data_ready_n_o)
    else $error("mode not power-down after reset");

  a_pd_all_off: assert property ( // R01
    mode_r == MD_PD |-> !pll_en_o && !conv_o[0].pwr && !conv_o[1].pwr)
    else $error("power-down left something running");

  a_disable_off: assert property ( // R03
    (mode_r != MD_PD) |-> conv_o[0].pwr == en_r[0] && conv_o[1].pwr == en_r[1])
    else $error("converter power does not follow its enable");

  a_pd_holds_data: assert property ( // R04
    mode_r == MD_PD && !wr_acc |=> $stable(data_r[0]) && $stable(data_r[1]))
    else $error("data changed while powered down");

  a_idle_rdy_high: assert property ( // R06
    mode_wr && avs_req_i.writedata[2:0] <= 3'(MD_IDLE) |=> data_ready_n_o)
    else $error("ready not released on power-down or idle entry");

  a_cal_to_idle: assert property ( // R07
    s_cal_run ##0 s_all_taken |=> mode_r == MD_IDLE)
    else $error("calibration did not return to idle");

  a_single_to_idle: assert property ( // R08
    mode_r == MD_SINGLE ##0 s_all_taken |=> mode_r == MD_IDLE &&
      (!data_ready_n_o || $past(rd_acc) || $past(en_r) == 2'b00))
    else $error("single conversion did not return to idle");

  a_cal_rate: assert property ( // R18
    is_cal |-> conv_o[0].rate == RATE_SLOWEST && conv_o[1].rate == RATE_SLOWEST)
    else $error("calibration not at slowest rate");

  a_zero_to_ofs: assert property ( // R14
    cal_ok && is_zero && take[0] && !wr_acc |=> ofs_r[0] == $past(sample_i[0].word[DW-1:0]))
    else $error("zero-scale result not stored in offset");

  a_full_to_gain: assert property ( // R15
    cal_ok && !is_zero && take[1] && !wr_acc |=> gain_r[1] == $past(sample_i[1].word[DW-1:0]))
    else $error("full-scale result not stored in gain");

  a_noref_block: assert property ( // R22
    s_cal_run ##0 (refm_r && !wr_acc) |=> err_r && $stable(gain_r[0]) && $stable(ofs_r[0]))
    else $error("missing reference did not block calibration");

  a_bus_answer: assert property ( // R05
    avs_waitrequest_o |=> !avs_waitrequest_o || !req)
    else $error("bus answer late");

endmodule

// file: acm_pkg.sv
// Shared constants and types for the converter mode and calibration control block
package acm_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_MAIN_CTRL = 8'h04;
  localparam logic [7:0] REG_AUX_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RATE = 8'h10;
  localparam logic [7:0] REG_DATA0 = 8'h14;
  localparam logic [7:0] REG_OFS0 = 8'h1C;
  localparam logic [7:0] REG_GAIN0 = 8'h24;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // ==========================================================
  // Field positions
  localparam int EN_BIT = 0;
  localparam int ST_MAIN_RDY = 0;
  localparam int ST_AUX_RDY = 1;
  localparam int ST_MAIN_ERR = 2;
  localparam int ST_NOREF = 3;

  // ==========================================================
  // Reset values and rates
  localparam logic [7:0] RATE_RESET = 8'h10;
  localparam logic [7:0] RATE_SLOWEST = 8'hFF;
  localparam logic [31:0] OFS_RESET = 32'h0000_0000;
  // Factory gain coefficient; unity gain at bit 23 for the default DW of 24
  localparam logic [31:0] FACTORY_GAIN = 32'h0080_0000;

  // ==========================================================
  // Operating modes; the mode register is the sequencer state
  typedef enum logic [2:0] {
    MD_PD = 3'b000,
    MD_IDLE = 3'b001,
    MD_CONT = 3'b010,
    MD_SINGLE = 3'b011,
    MD_INT_ZERO = 3'b100,
    MD_INT_FULL = 3'b101,
    MD_SYS_ZERO = 3'b110,
    MD_SYS_FULL = 3'b111
  } acm_mode_t;

  typedef enum logic [1:0] {
    IN_EXT = 2'b00,
    IN_ZERO = 2'b01,
    IN_FULL = 2'b10
  } acm_insel_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } acm_avs_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } acm_sample_t;

  typedef struct packed {
    logic pwr;
    acm_insel_t in_sel;
    logic [7:0] rate;
  } acm_conv_t;

endpackage

// file: acm_filter_model.sv
// Behavioural filter source standing at the far side of both converters
`timescale 1ns/1ps
module acm_filter_model
  import acm_pkg::*;
#(
  parameter logic [31:0] ZERO_W = 32'h0000_0123,
  parameter logic [31:0] FULL_W = 32'h0074_5678
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Converter controls and stimulus
  input wire acm_pkg::acm_conv_t [1:0] conv_i,
  input wire logic [1:0] go_i,
  input wire logic [1:0][31:0] ext_i,
  // Filter words
  output acm_pkg::acm_sample_t [1:0] sample_o
);
  // ==========================================================
  // One word per request, only from a powered converter
  always @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      sample_o[k].valid <= !srst_i && go_i[k] && conv_i[k].pwr;
      if (srst_i) begin
        sample_o[k].word <= '0;
      end else if (go_i[k] && conv_i[k].pwr) begin
        case (conv_i[k].in_sel)
          IN_ZERO: sample_o[k].word <= ZERO_W;
          IN_FULL: sample_o[k].word <= FULL_W;
          default: sample_o[k].word <= ext_i[k];
        endcase
      end else begin
        // Stale words toggle so a late capture cannot pass by luck
        sample_o[k].word <= ~sample_o[k].word;
      end
    end
  end
endmodule

// file: acm_mode_cal_tb.sv
// Self-checking bench for the converter mode and calibration control block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module acm_mode_cal_tb;
  import acm_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [31:0] ZW = 32'h0000_0123;
  localparam logic [31:0] FW = 32'h0074_5678;
  logic clk_i;
  logic srst_i = 1'b1;
  acm_avs_req_t req = '0;
  logic [31:0] rdata;
  logic avs_wait;
  acm_sample_t [1:0] smp;
  logic ref_miss = 1'b0;
  acm_conv_t [1:0] conv;
  logic pll_en, aux_en, rdy_n;
  logic [1:0] go = '0;
  logic [1:0][31:0] ext = '0;
  logic [31:0] expq[$];
  logic [31:0] mskq[$];
  logic [31:0] eofs[2];
  logic [31:0] egain[2];
  logic [31:0] w;
  int num_errors = 0;
  int compares = 0;

  acm_mode_cal i_acm_mode_cal (.clk_i(clk_i), .srst_i(srst_i), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(avs_wait), .sample_i(smp),
    .ref_missing_i(ref_miss), .conv_o(conv), .pll_en_o(pll_en), .aux_func_en_o(aux_en),
    .data_ready_n_o(rdy_n));
  acm_filter_model #(.ZERO_W(ZW), .FULL_W(FW)) i_acm_filter_model (.clk_i(clk_i),
    .srst_i(srst_i), .conv_i(conv), .go_i(go), .ext_i(ext), .sample_o(smp));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_sim;
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Bus master; reads note their expected word for the monitor
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hF;
    if (!wr) begin
      expq.push_back(d);
      mskq.push_back(m);
    end
    @(posedge clk_i);
    while (avs_wait) @(posedge clk_i);
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, '0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    bus(1'b0, a, e, m);
  endtask

  // One filter word per selected channel, then time to land and return to idle
  task automatic fire(input logic [1:0] m);
    go <= m;
    @(posedge clk_i);
    go <= 2'b00;
    repeat (3) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (req.read && !avs_wait) begin
      if (expq.size() == 0) begin
        num_errors++;
        $display("unexpected at %0t: read answered with nothing expected", $time);
      end else begin
        `CHK(rdata & mskq[0], expq[0] & mskq[0])
        void'(expq.pop_front());
        void'(mskq.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'hFD84));
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({rdy_n, pll_en, conv[0].pwr, conv[1].pwr}, 4'b1000)
    rd(REG_MODE, 32'h0);
    rd(REG_GAIN0, FACTORY_GAIN);
    rd(REG_GAIN0 + REG_STRIDE, FACTORY_GAIN);
    rd(REG_RATE, 32'(RATE_RESET));
    wr(8'hFC, '1);
    rd(8'hFC, 32'h0);
    // Main only: internal zero-scale
    wr(REG_MAIN_CTRL, 32'h1);
    wr(REG_MODE, 32'h4);
    `CHK({conv[1].pwr, conv[0].pwr}, 2'b01)
    fire(2'b11);
    `CHK(rdy_n, 1'b0)
    rd(REG_STATUS, 32'h1);
    rd(REG_MODE, 32'h1);
    rd(REG_OFS0, ZW);
    rd(REG_OFS0 + REG_STRIDE, 32'h0);
    wr(REG_MODE, 32'h1);
    `CHK(rdy_n, 1'b1)
    eofs = '{ZW, 32'h0};
    egain = '{FACTORY_GAIN, FACTORY_GAIN};
    // Every calibration code, zero-scale before full-scale, both channels
    wr(REG_AUX_CTRL, 32'h1);
    for (int m = 4; m < 8; m++) begin
      ext[0] <= $urandom & 32'h003F_FFFF;
      ext[1] <= $urandom & 32'h003F_FFFF;
      @(posedge clk_i);
      wr(REG_MODE, 32'(m));
      for (int k = 0; k < 2; k++) begin
        `CHK(conv[k].rate, RATE_SLOWEST)
        `CHK(conv[k].in_sel, (m == 4) ? IN_ZERO : ((m == 5) ? IN_FULL : IN_EXT))
        if (m % 2 == 1)
          egain[k] = (m == 5) ? FW : ext[k];
        else
          eofs[k] = (m == 4) ? ZW : ext[k];
      end
      fire(2'b11);
      rd(REG_MODE, 32'h1);
    end
    for (int k = 0; k < 2; k++) begin
      rd(REG_OFS0 + 8'(k * 4), eofs[k]);
      rd(REG_GAIN0 + 8'(k * 4), egain[k]);
    end
    // Single conversion with correction
    wr(REG_MODE, 32'h1);
    wr(REG_AUX_CTRL, 32'h0);
    wr(REG_OFS0, 32'd16);
    wr(REG_GAIN0, 32'h0040_0000);
    wr(REG_RATE, 32'h20);
    w = ($urandom & 32'h003F_FFFF) | 32'h100;
    ext[0] <= w;
    wr(REG_MODE, 32'h3);
    `CHK(conv[0].rate, 8'h20)
    fire(2'b01);
    `CHK(rdy_n, 1'b0)
    rd(REG_MODE, 32'h1);
    rd(REG_DATA0, (w - 32'd16) >> 1);
    rd(REG_STATUS, 32'h0, 32'h3);
    // Both converters off in a running mode, then power-down
    wr(REG_MAIN_CTRL, 32'h0);
    wr(REG_MODE, 32'h2);
    `CHK({conv[1].pwr, conv[0].pwr, pll_en, aux_en}, 4'b0011)
    fire(2'b11);
    rd(REG_DATA0, (w - 32'd16) >> 1);
    wr(REG_MODE, 32'h0);
    `CHK({pll_en, aux_en, rdy_n}, 3'b001)
    rd(REG_DATA0, (w - 32'd16) >> 1);
    // Reference already missing when a full-scale calibration starts
    wr(REG_MAIN_CTRL, 32'h1);
    ref_miss <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(REG_MODE, 32'h5);
    fire(2'b01);
    rd(REG_STATUS, 32'hC, 32'hC);
    rd(REG_GAIN0, 32'h0040_0000);
    // Conversions without a reference read as all ones
    wr(REG_MODE, 32'h2);
    fire(2'b01);
    rd(REG_DATA0, 32'h00FF_FFFF);
    ref_miss <= 1'b0;
    // Second reset mid-run restores defaults; a write held across it must not land
    srst_i <= 1'b1;
    req.write <= 1'b1;
    req.address <= REG_RATE;
    req.writedata <= 32'h55;
    req.byteenable <= 4'hF;
    repeat (3) @(posedge clk_i);
    `CHK(avs_wait, 1'b1)
    srst_i <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_i);
    `CHK(rdy_n, 1'b1)
    rd(REG_MODE, 32'h0);
    rd(REG_GAIN0, FACTORY_GAIN);
    rd(REG_OFS0, OFS_RESET);
    rd(REG_RATE, 32'(RATE_RESET));
    end_sim();
  end
endmodule
